// ---- ntdpll_pkg.sv ----
package ntdpll_pkg;

  localparam longint unsigned PCLK_HZ = 125_000_000;
  localparam longint unsigned FRAME_HZ = 8_000;
  localparam longint unsigned F16_HZ = 16_384_000;
  localparam longint unsigned T1H_HZ = 12_352_000;
  localparam longint unsigned DS2H_HZ = 12_624_000;
  localparam longint unsigned F19_HZ = 19_440_000;
  localparam longint unsigned REF_T1_HZ = 1_544_000;
  localparam longint unsigned REF_E1_HZ = 2_048_000;

  localparam int FRAME_CYC = int'(PCLK_HZ / FRAME_HZ);
  localparam int HALF_CYC = FRAME_CYC / 2;
  localparam int LOSS_CYC_DEFAULT = 2 * FRAME_CYC;
  localparam int HALF_PER_FRAME = int'(2 * F16_HZ / FRAME_HZ);
  localparam logic [11:0] HC_LAST = 12'(HALF_PER_FRAME - 1);

  // Pulse widths in ns, converted to half periods of the 16.384 MHz clock
  localparam longint unsigned FP_E1_NS = 244;
  localparam longint unsigned FP_SHORT_NS = 122;
  localparam longint unsigned FP_SYNC_NS = 488;
  localparam logic [11:0] HC_E1 = 12'((FP_E1_NS * 2 * F16_HZ + 500_000_000) / 1_000_000_000);
  localparam logic [11:0] HC_SHORT = 12'((FP_SHORT_NS * 2 * F16_HZ + 500_000_000) / 1_000_000_000);
  localparam logic [11:0] HC_SYNC = 12'((FP_SYNC_NS * 2 * F16_HZ + 500_000_000) / 1_000_000_000);
  localparam logic [11:0] HC_16 = 12'h002;

  // Loop filter: one update per 8 kHz comparison, so the corner is rate independent
  localparam real LF_CORNER_HZ = 1.9;
  localparam int LF_SHIFT = $clog2(int'(real'(FRAME_HZ) / (6.2832 * LF_CORNER_HZ)) + 1) - 1;
  localparam int LF_SHIFT_FAST = LF_SHIFT - 4;
  localparam int FRAC_BITS = 8;
  localparam int GAIN_SH = 5;
  localparam logic signed [31:0] CORR_MAX = 32'sd268435;
  localparam int LOCK_TIME_S = 30;
  localparam int FAST_LOCK_MS = 500;

  localparam int CAPTURE_PPM = 230;
  localparam logic [19:0] IMP_TOL_CYC = 20'((CAPTURE_PPM * FRAME_CYC + 999_999) / 1_000_000 + 1);
  localparam logic [3:0] RECOVER_LAST = 4'h7;
  localparam logic [15:0] LOCK_TH_CYC = 16'h0010;
  localparam logic [15:0] LOCK_SLIP_CYC = 16'h0002;
  localparam logic [4:0] LOCK_LAST = 5'h0f;

  localparam logic [1:0] RATE_19M = 2'b00;
  localparam logic [1:0] RATE_8K = 2'b01;
  localparam logic [1:0] RATE_T1 = 2'b10;
  localparam logic [1:0] RATE_E1 = 2'b11;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PHASE = 12'h008;
  localparam logic [11:0] REG_FILTER = 12'h00c;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_QUICK_BIT = 1;
  localparam int CTRL_RATE_LSB = 2;

  function automatic logic [31:0] nco_inc(longint unsigned f);
    return 32'(((2 * f) << 32) / PCLK_HZ);
  endfunction

  function automatic logic [11:0] ref_div_last(logic [1:0] rate);
    unique case (rate)
      RATE_19M: return 12'(F19_HZ / FRAME_HZ - 1);
      RATE_8K: return 12'h000;
      RATE_T1: return 12'(REF_T1_HZ / FRAME_HZ - 1);
      RATE_E1: return 12'(REF_E1_HZ / FRAME_HZ - 1);
    endcase
  endfunction

  function automatic logic [15:0] abs16(logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  typedef struct packed {
    logic [31:0] acc;
    logic tick;
  } ntdpll_nco_t;

  typedef struct packed {
    logic ctrl_mode;
    logic ctrl_quick;
    logic [1:0] ctrl_rate;
    logic mode_q;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [11:0] ref_div;
    logic [19:0] ref_age;
    logic [15:0] fb_age;
    logic signed [15:0] phase_err;
    logic signed [15:0] prev_err;
    logic signed [31:0] filt;
    logic signed [31:0] corr;
    logic impaired;
    logic [3:0] good_cnt;
    logic lock;
    logic [4:0] lock_cnt;
    logic acquire;
    logic [11:0] hc;
    logic [2:0] t1_cnt;
    logic t1_hi;
    logic t1_clk;
    logic ds2_hi;
    logic ds2_clk;
    logic c19_clk;
    logic c16;
    logic c8;
    logic c4;
    logic c2;
    logic fp_e1_n;
    logic fp_short;
    logic fp16_n;
    logic tx_sync;
    logic rx_sync;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ntdpll_state_t;

  localparam ntdpll_state_t RST_STATE = '{fp_e1_n: 1'b1, fp16_n: 1'b1, acquire: 1'b1, default: '0};

endpackage

// ---- ntdpll_nco.sv ----
`timescale 1ns/100ps
module ntdpll_nco
  import ntdpll_pkg::*;
#(
  parameter logic [31:0] NOM_INC = 32'h20000000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [31:0] corr,
  output logic tick
);

  if (NOM_INC == 32'h0 || NOM_INC[31])
  begin : g_chk
    $error("NOM_INC must be nonzero and below half scale");
  end

  ntdpll_nco_t r;
  ntdpll_nco_t n;
  logic signed [63:0] prod;
  logic [31:0] inc;
  logic [32:0] sum;

  // Correction is a fractional frequency offset, so every oscillator moves by the same ppm
  always_comb
  begin
    n = r;
    prod = 64'(corr) * $signed({32'h0, NOM_INC});
    inc = NOM_INC + prod[61:30];
    sum = {1'b0, r.acc} + {1'b0, inc};
    n.acc = sum[31:0];
    n.tick = sum[32];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign tick = r.tick;

endmodule

// ---- ntdpll_top.sv ----
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module ntdpll_top
  import ntdpll_pkg::*;
#(
  parameter int LOSS_CYC = LOSS_CYC_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ref_in,
  output logic clk_16m_out,
  output logic clk_8m_out,
  output logic clk_4m_out,
  output logic clk_2m_out,
  output logic clk_t1_out,
  output logic clk_ds2_out,
  output logic clk_19m_out,
  output logic frame_pulse_e1_n,
  output logic frame_pulse_short,
  output logic frame_pulse_16m_n,
  output logic tx_sync_pulse,
  output logic rx_sync_pulse,
  output logic lock_out,
  output logic impairment_flag
);

  if (LOSS_CYC <= FRAME_CYC || LOSS_CYC >= (1 << 20))
  begin : g_chk
    $error("LOSS_CYC must exceed one frame and fit 20 bits");
  end

  localparam logic [19:0] LOSS_LAST = 20'(LOSS_CYC);

  ntdpll_state_t r;
  ntdpll_state_t n;
  logic tick16;
  logic tick_t1;
  logic tick_ds2;
  logic tick_19;
  logic freerun;
  logic ref_fall;
  logic ref_tick;
  logic fb_tick;
  logic signed [15:0] err;
  logic signed [31:0] target;
  logic signed [31:0] filt_n;
  logic signed [31:0] corr_raw;
  logic [19:0] dev;
  logic ref_bad;
  logic lock_good;
  logic access;
  logic [1:0] wr_rate;

  // One accumulator per internal high-rate clock, all sharing one correction
  ntdpll_nco #(.NOM_INC(nco_inc(F16_HZ))) u_nco16 (.pclk(pclk), .presetn(presetn), .corr(r.corr), .tick(tick16));
  ntdpll_nco #(.NOM_INC(nco_inc(T1H_HZ))) u_nco_t1 (.pclk(pclk), .presetn(presetn), .corr(r.corr), .tick(tick_t1));
  ntdpll_nco #(.NOM_INC(nco_inc(DS2H_HZ))) u_nco_ds2 (.pclk(pclk), .presetn(presetn), .corr(r.corr), .tick(tick_ds2));
  ntdpll_nco #(.NOM_INC(nco_inc(F19_HZ))) u_nco19 (.pclk(pclk), .presetn(presetn), .corr(r.corr), .tick(tick_19));

  always_comb
  begin
    n = r;
    freerun = r.mode_q | r.impaired;
    access = psel & penable;
    wr_rate = pwdata[CTRL_RATE_LSB +: 2];
    // Reference acts on its falling edge; ref_s1 only feeds ref_s2
    n.ref_s1 = ref_in;
    n.ref_s2 = r.ref_s1;
    n.ref_s3 = r.ref_s2;
    ref_fall = r.ref_s3 & ~r.ref_s2;
    ref_tick = 1'b0;
    if (ref_fall)
    begin
      if (r.ref_div >= ref_div_last(r.ctrl_rate))
      begin
        n.ref_div = '0;
        ref_tick = 1'b1;
      end
      else
        n.ref_div = r.ref_div + 12'h001;
    end
    // Feedback is the frame boundary of the 16.384 MHz chain
    fb_tick = tick16 && (r.hc == HC_LAST);
    if (tick16)
      n.hc = r.hc + 12'h001;
    if (fb_tick)
    begin
      n.fb_age = '0;
      n.mode_q = r.ctrl_mode;
    end
    else if (r.fb_age != 16'(FRAME_CYC - 1))
      n.fb_age = r.fb_age + 16'h0001;
    if (ref_tick)
      n.ref_age = '0;
    else if (r.ref_age != LOSS_LAST)
      n.ref_age = r.ref_age + 20'h00001;
    // Positive error means the reference arrived after the feedback
    err = (r.fb_age <= 16'(HALF_CYC)) ? $signed(r.fb_age) : $signed(r.fb_age - 16'(FRAME_CYC));
    dev = (r.ref_age > 20'(FRAME_CYC)) ? r.ref_age - 20'(FRAME_CYC) : 20'(FRAME_CYC) - r.ref_age;
    // First interval after reset or a restart is not a whole frame, so it is not judged
    ref_bad = (dev > IMP_TOL_CYC) && !(r.acquire && !r.impaired);
    if (r.ref_age == LOSS_LAST)
    begin
      n.impaired = 1'b1;
      n.good_cnt = '0;
    end
    else if (ref_tick)
    begin
      if (ref_bad)
      begin
        n.impaired = 1'b1;
        n.good_cnt = '0;
      end
      else if (r.impaired)
      begin
        n.good_cnt = r.good_cnt + 4'h1;
        if (r.good_cnt == RECOVER_LAST)
          n.impaired = 1'b0;
      end
    end
    target = 32'(err) <<< FRAC_BITS;
    filt_n = r.filt + ((target - r.filt) >>> (r.ctrl_quick ? LF_SHIFT_FAST : LF_SHIFT));
    corr_raw = filt_n <<< GAIN_SH;
    lock_good = (abs16(err) < LOCK_TH_CYC) && (abs16(err - r.prev_err) <= LOCK_SLIP_CYC);
    if (freerun || n.impaired || n.mode_q)
    begin
      // Loop held open; next-state terms drop lock in the cycle freerun begins
      n.filt = '0;
      n.corr = '0;
      n.acquire = 1'b1;
      n.lock = 1'b0;
      n.lock_cnt = '0;
    end
    else if (ref_tick)
    begin
      if (r.acquire)
      begin
        // Phase step onto the first reference frame instead of a long pull
        n.hc = '0;
        n.fb_age = '0;
        n.acquire = 1'b0;
        n.phase_err = '0;
        n.prev_err = '0;
      end
      else
      begin
        n.phase_err = err;
        n.prev_err = err;
        n.filt = filt_n;
        if (corr_raw > CORR_MAX)
          n.corr = -CORR_MAX;
        else if (corr_raw < -CORR_MAX)
          n.corr = CORR_MAX;
        else
          n.corr = -corr_raw;
        if (!lock_good)
        begin
          n.lock = 1'b0;
          n.lock_cnt = '0;
        end
        else if (r.lock_cnt == LOCK_LAST)
          n.lock = 1'b1;
        else
          n.lock_cnt = r.lock_cnt + 5'h01;
      end
    end
    // Dividers of the high-rate clocks
    if (tick_t1)
    begin
      n.t1_hi = ~r.t1_hi;
      n.t1_cnt = r.t1_cnt + 3'h1;
      if (r.t1_cnt == 3'h7)
        n.t1_clk = ~r.t1_clk;
    end
    if (tick_ds2)
    begin
      n.ds2_hi = ~r.ds2_hi;
      if (r.ds2_hi)
        n.ds2_clk = ~r.ds2_clk;
    end
    if (tick_19)
      n.c19_clk = ~r.c19_clk;
    // E1 clocks and frame pulses all decoded from one half-period count
    n.c16 = ~n.hc[0];
    n.c8 = ~n.hc[1];
    n.c4 = ~n.hc[2];
    n.c2 = ~n.hc[3];
    n.fp_e1_n = !(n.hc < HC_E1);
    n.fp_short = n.hc < HC_SHORT;
    n.fp16_n = !(n.hc < HC_16);
    n.tx_sync = n.hc < HC_SYNC;
    n.rx_sync = n.hc < HC_SYNC;
    // APB slave: one wait state, so read data and errors leave a flip-flop
    if (access && !r.pready)
    begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      unique case (paddr)
        REG_CTRL: n.prdata = {28'h0, r.ctrl_rate, r.ctrl_quick, r.ctrl_mode};
        REG_STATUS: n.prdata = {28'h0, r.acquire, freerun, r.impaired, r.lock};
        REG_PHASE: n.prdata = 32'(r.phase_err);
        REG_FILTER: n.prdata = r.corr;
        default:
        begin
          n.prdata = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    else if (access && r.pready)
    begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && paddr == REG_CTRL)
      begin
        n.ctrl_mode = pwdata[CTRL_MODE_BIT];
        n.ctrl_quick = pwdata[CTRL_QUICK_BIT];
        n.ctrl_rate = wr_rate;
        if (wr_rate != r.ctrl_rate)
        begin
          // A rate change invalidates the divider phase, so clear divider and loop and restart acquisition; impairment state is kept
          n.ref_div = '0;
          n.acquire = 1'b1;
          n.filt = '0;
          n.corr = '0;
          n.lock = 1'b0;
          n.lock_cnt = '0;
        end
      end
    end
    else
    begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= RST_STATE;
    else
      r <= n;
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign clk_16m_out = r.c16;
  assign clk_8m_out = r.c8;
  assign clk_4m_out = r.c4;
  assign clk_2m_out = r.c2;
  assign clk_t1_out = r.t1_clk;
  assign clk_ds2_out = r.ds2_clk;
  assign clk_19m_out = r.c19_clk;
  assign frame_pulse_e1_n = r.fp_e1_n;
  assign frame_pulse_short = r.fp_short;
  assign frame_pulse_16m_n = r.fp16_n;
  assign tx_sync_pulse = r.tx_sync;
  assign rx_sync_pulse = r.rx_sync;
  assign lock_out = r.lock;
  assign impairment_flag = r.impaired;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_freerun_nominal: assert property (freerun |=> r.corr == 32'sh0)
    else $error("correction not zero in freerun");
  a_corr_bounded: assert property (r.corr <= CORR_MAX && r.corr >= -CORR_MAX)
    else $error("correction outside clamp");
  a_clk8_on_rise16: assert property ($changed(clk_8m_out) && !$past(r.acquire) |-> $rose(clk_16m_out))
    else $error("8 MHz output moved off a 16 MHz rising edge");
  a_clk2_follows4: assert property ($changed(clk_2m_out) && !$past(r.acquire) |-> $rose(clk_4m_out))
    else $error("2 MHz output moved off a 4 MHz rising edge");
  a_t1_div_eight: assert property ($changed(clk_t1_out) |-> $changed(r.t1_hi) && r.t1_cnt == 3'h0)
    else $error("T1 output toggled off its divide point");
  a_loss_to_freerun: assert property (r.ref_age == LOSS_LAST |=> impairment_flag ##1 !lock_out)
    else $error("reference loss did not force freerun");
  a_mode_on_frame: assert property ($changed(r.mode_q) |-> $past(fb_tick) ##1 frame_pulse_short)
    else $error("mode sampled away from frame start");
  a_e1_covers_short: assert property (frame_pulse_short |-> !frame_pulse_e1_n)
    else $error("short pulse outside E1 frame pulse");
  a_e1_pulse_frame: assert property ($fell(frame_pulse_e1_n) |-> frame_pulse_short && !frame_pulse_16m_n)
    else $error("frame pulses not aligned at frame start");
  a_lock_normal_only: assert property (lock_out |-> !impairment_flag && !r.mode_q)
    else $error("lock shown while in freerun");
  a_err_in_half: assert property (ref_tick && !freerun && !r.acquire |=> abs16(r.phase_err) <= 16'(HALF_CYC))
    else $error("phase error outside half frame");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not after one wait state");

  c_lock_reached: cover property ($rose(lock_out));
  c_impaired: cover property ($rose(impairment_flag));
  c_recovered: cover property ($fell(impairment_flag));
  c_mode_freerun: cover property ($rose(r.mode_q));

endmodule

// ---- ntdpll_ref_src.sv ----
`timescale 1ns/100ps
module ntdpll_ref_src
  import ntdpll_pkg::*;
(
  input wire logic run,
  input wire logic [1:0] rate,
  output logic ref_in
);
  real half_ns;
  realtime next_t;

  // Rate code to line frequency
  always_comb
  begin
    case (rate)
      RATE_19M: half_ns = 5.0e8 / real'(F19_HZ);
      RATE_8K: half_ns = 5.0e8 / real'(FRAME_HZ);
      RATE_T1: half_ns = 5.0e8 / real'(REF_T1_HZ);
      default: half_ns = 5.0e8 / real'(REF_E1_HZ);
    endcase
  end

  // Edge times kept in real time so the 100 ps grid never builds up drift
  initial
  begin
    ref_in = 1'b1;
    forever
    begin : gen
      wait (run === 1'b1);
      next_t = $realtime;
      while (run === 1'b1)
      begin
        next_t = next_t + half_ns;
        #(next_t - $realtime);
        ref_in = ~ref_in;
      end
    end
  end

  // Stop or rate change restarts the edge train at once; a stopped line holds its level
  always @(run or rate)
    disable gen;
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb
  import ntdpll_pkg::*;
;
  localparam int LOSS = 16000;
  localparam int WIN = FRAME_CYC + FRAME_CYC / 8;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic ref_run;
  logic [1:0] ref_rate;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire ref_in;
  wire lock;
  wire imp;
  wire [6:0] ck;
  wire [4:0] fp;
  int error_cnt;
  int n_checks;

  always #4 pclk = ~pclk;

  ntdpll_top #(.LOSS_CYC(LOSS)) ntdpll_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ref_in(ref_in),
    .clk_16m_out(ck[0]), .clk_8m_out(ck[1]), .clk_4m_out(ck[2]), .clk_2m_out(ck[3]), .clk_t1_out(ck[4]),
    .clk_ds2_out(ck[5]), .clk_19m_out(ck[6]), .frame_pulse_e1_n(fp[0]), .frame_pulse_short(fp[1]),
    .frame_pulse_16m_n(fp[2]), .tx_sync_pulse(fp[3]), .rx_sync_pulse(fp[4]), .lock_out(lock),
    .impairment_flag(imp)
  );

  ntdpll_ref_src ntdpll_ref_src_inst (.run(ref_run), .rate(ref_rate), .ref_in(ref_in));

  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail_wait();
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_near(input int seen, input int exp, input int tol);
    n_checks++;
    if (seen < exp - tol || seen > exp + tol)
    begin
      error_cnt++;
      $display("Error at %0t: count %0d expected %0d", $time, seen, exp);
    end
  endtask

  // Starts just after a rising edge; answer taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [32:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 20)
        fail_wait();
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic wait_short();
    logic pv;
    int n;
    pv = 1'b1;
    n = 0;
    while (!(fp[1] === 1'b1 && pv === 1'b0))
    begin
      pv = fp[1];
      @(negedge pclk);
      n++;
      if (n > 2 * FRAME_CYC)
        fail_wait();
    end
    @(posedge pclk);
  endtask

  task automatic t_regs();
    logic [32:0] r;
    apb(1'b0, REG_CTRL, 32'h0, r);
    check(r, 33'h0);
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r, 33'h8);
    check({32'h0, lock}, 33'h0);
    apb(1'b0, REG_FILTER, 32'h0, r);
    check(r, 33'h0);
    apb(1'b1, REG_STATUS, 32'hf, r);
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r, 33'h8);
    apb(1'b1, 12'h010, 32'h5, r);
    check(r, 33'h100000000);
    apb(1'b0, REG_CTRL, 32'h0, r);
    check(r, 33'h0);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, REG_CTRL, 32'(k * 4 + 2), r);
      apb(1'b0, REG_CTRL, 32'h0, r);
      check(r, 33'(k * 4 + 2));
    end
    apb(1'b1, REG_CTRL, 32'h0, r);
  endtask

  // Every rate code with its matching line; a wrong divider shows as an impaired interval
  task automatic t_rates();
    logic [32:0] r;
    int n;
    for (int k = 0; k < 4; k++)
    begin
      ref_run = 1'b0;
      do_reset();
      apb(1'b1, REG_CTRL, 32'(k * 4), r);
      ref_rate = 2'(k);
      ref_run = 1'b1;
      n = 0;
      do
      begin
        apb(1'b0, REG_STATUS, 32'h0, r);
        n++;
        if (n > FRAME_CYC / 2)
          fail_wait();
      end while (r[3] !== 1'b0);
      @(negedge pclk);
      check({32'h0, imp}, 33'h0);
      @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0, r);
      check(r & 33'h6, 33'h0);
    end
    ref_run = 1'b0;
    n = 0;
    while (imp !== 1'b1)
    begin
      @(negedge pclk);
      n++;
      if (n > LOSS + FRAME_CYC)
        fail_wait();
    end
    @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r & 33'h6, 33'h6);
  endtask

  task automatic measure();
    int rise[7], hi[7], ex[7], wid[5], rn[5], ns[5];
    int last, per, dif;
    longint unsigned hz[7];
    logic [6:0] pc;
    logic [4:0] pa, pp;
    rise = '{default: 0};
    hi = '{default: 0};
    wid = '{default: 0};
    rn = '{default: 0};
    ns = '{244, 122, 61, 488, 488};
    hz = '{F16_HZ, F16_HZ / 2, F16_HZ / 4, F16_HZ / 8, T1H_HZ / 8, DS2H_HZ / 2, F19_HZ};
    for (int k = 0; k < 7; k++)
      ex[k] = int'(hz[k] * WIN / PCLK_HZ);
    last = -1;
    per = 0;
    dif = 0;
    pc = ck;
    pp = fp ^ 5'b00101;
    for (int i = 0; i < WIN; i++)
    begin
      @(negedge pclk);
      pa = fp ^ 5'b00101;
      for (int k = 0; k < 7; k++)
      begin
        rise[k] += int'(ck[k] & !pc[k]);
        hi[k] += int'(ck[k]);
      end
      for (int k = 0; k < 5; k++)
      begin
        if (!pa[k] && rn[k] > 0)
          wid[k] = rn[k];
        rn[k] = pa[k] ? rn[k] + 1 : 0;
      end
      if (!pa[0] && pp[0])
      begin
        per = (last < 0) ? per : i - last;
        last = i;
      end
      dif += int'(fp[3] !== fp[4]);
      pc = ck;
      pp = pa;
    end
    @(posedge pclk);
    for (int k = 0; k < 7; k++)
    begin
      check_near(rise[k], ex[k], 2);
      check_near(hi[k], WIN / 2, WIN / 16);
    end
    for (int k = 0; k < 5; k++)
      check_near(wid[k] * 8, ns[k], 12);
    check_near(per, FRAME_CYC, 2);
    check_near(dif, 0, 0);
  endtask

  // Mode write lands just after a frame start, so it must not act before the next one
  task automatic t_freerun();
    logic [32:0] r;
    do_reset();
    apb(1'b1, REG_CTRL, 32'h4, r);
    ref_rate = RATE_8K;
    ref_run = 1'b1;
    wait_short();
    apb(1'b1, REG_CTRL, 32'h5, r);
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r & 33'h4, 33'h0);
    wait_short();
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r & 33'h6, 33'h4);
    measure();
    apb(1'b1, REG_CTRL, 32'h4, r);
    wait_short();
    apb(1'b0, REG_STATUS, 32'h0, r);
    check(r & 33'h6, 33'h0);
    ref_run = 1'b0;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ref_run = 1'b0;
    ref_rate = RATE_8K;
    error_cnt = 0;
    n_checks = 0;
    do_reset();
    t_regs();
    t_rates();
    t_freerun();
    stop_test();
  end
endmodule
